// >>> hw/otp_boot_loader_sequencer.sv
// Boot sequencer: loads OTP configuration and user image into RAM, then releases the CPU.
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ps
module otp_boot_loader_sequencer #(
  parameter int FIXED_CYCLES = boot_pkg::FIXED_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wake_i,
  input wire logic dbg_reset_i,
  input wire logic retest_i,
  input wire logic [7:0] otp_rdata_i,
  input wire logic otp_ack_i,
  output boot_pkg::otp_req_s otp_req_o,
  output boot_pkg::ram_wr_s ram_wr_o,
  output logic cpu_run_o,
  output logic [15:0] cpu_pc_o,
  output logic periph_rst_o,
  output logic [7:0] port_latch_o,
  output logic port_od_o,
  output logic osc_int_sel_o,
  output logic debug_en_o,
  output logic prog_allow_o,
  input wire logic [boot_pkg::WB_AW-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import boot_pkg::*;
  localparam int FCW = $clog2(FIXED_CYCLES + 1);
  localparam int BCW = $clog2(BOOT_LIMIT_CYC + 2);
  function automatic logic lvl_loads(input logic [2:0] l);
    return (l == LVL_USER) || (l == LVL_RUN);
  endfunction
  function automatic logic lvl_run(input logic [2:0] l);
    return l == LVL_RUN;
  endfunction
  state_e state;
  state_e next_state;
  state_e after_load;
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;
  logic [2:0] cfg_idx;
  logic [2:0] level;
  logic autorun;
  logic [15:0] ubeg;
  logic [15:0] ulen;
  logic [7:0] internal_data_ram_len;
  logic [15:0] copied;
  logic [FCW-1:0] fixed_cnt;
  logic [PACE_W-1:0] pace_cnt;
  logic [BCW-1:0] boot_cyc;
  logic run_por;
  logic run_sys;
  logic skip;
  logic [31:0] flags_word;
  logic [31:0] prot_word;
  // ---------------------------------------------------------------
  // pin synchronisers and boot triggers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      pin_prev <= 3'h0;
    end
    else
    begin
      pin_meta <= {retest_i, dbg_reset_i, wake_i};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end
  // a wake from shutdown restores supply, so it acts as a power-on reset
  wire wake_rise = pin_sync[0] & ~pin_prev[0]; // R4
  wire dbg_rise = pin_sync[1] & ~pin_prev[1];
  wire retest_s = pin_sync[2];
  wire restart = wake_rise | dbg_rise; // R11
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire cfg_take = (state == S_CFG_WAIT) && otp_ack_i;
  wire user_take = (state == S_USER_WAIT) && otp_ack_i;
  wire cfg_last = cfg_idx == 3'(CFG_BYTES - 1);
  wire fixed_done = fixed_cnt == FCW'(FIXED_CYCLES);
  wire pace_last = pace_cnt == PACE_W'(BYTE_PACE_CYC - 1);
  wire boot_done = (state == S_WAIT_RUN) || (state == S_RUN);
  // the reserved tail of the OTP is never part of the image
  wire [15:0] user_room = (ubeg < OTP_USER_LIMIT) ? OTP_USER_LIMIT - ubeg : 16'h0000; // R18
  wire [15:0] ulen_eff = (ulen > user_room) ? user_room : ulen; // R19
  wire copy_more = copied < ulen_eff;
  wire [15:0] user_sum = ubeg + copied;
  wire to_internal_data_ram = copied < {8'h00, internal_data_ram_len};
  wire [15:0] uram_off = copied - {8'h00, internal_data_ram_len};
  wire [RAM_AW-1:0] cfg_ram_addr = BOOT_BLK_BASE + {{(RAM_AW-3){1'b0}}, cfg_idx}; // R12
  wire [RAM_AW-1:0] user_ram_addr = to_internal_data_ram ? {{(RAM_AW-8){1'b0}}, copied[7:0]} : uram_off[RAM_AW-1:0]; // R14
  // skip is not honoured on a run part, otherwise it would reopen debug
  wire skip_load = skip && !lvl_run(level); // R20
  wire debug_allow = !lvl_run(level) || retest_s; // R15 R16 R22
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr_flags = wb_req && wb_we_i && wb_sel_i[0] && (wb_adr_i == REG_BOOT_FLAGS);
  // software set of a run request beats the boot-start clear
  wire next_run_por = wr_flags ? wb_dat_i[FLG_RUN_POR] : (restart ? 1'b0 : run_por);
  wire next_run_sys = wr_flags ? wb_dat_i[FLG_RUN_SYS] : (restart ? 1'b0 : run_sys);
  wire next_skip = wr_flags ? wb_dat_i[FLG_SKIP] : (wake_rise ? 1'b0 : skip);
  assign after_load = (lvl_run(level) || ((level == LVL_USER) && autorun)) ? S_RUN : S_WAIT_RUN; // R15 R22
  // ---------------------------------------------------------------
  // boot sequence
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_RESET: next_state = S_CFG_RD; // R7
      S_CFG_RD: next_state = S_CFG_WAIT; // R9
      S_CFG_WAIT:
      begin
        if (otp_ack_i)
          next_state = cfg_last ? S_FIXED : S_CFG_RD;
      end
      S_FIXED:
      begin
        if (fixed_done)
        begin
          if (!lvl_loads(level) || skip_load)
            next_state = S_WAIT_RUN; // R13 R20
          else if (copy_more)
            next_state = S_USER_RD; // R14
          else
            next_state = after_load;
        end
      end
      S_USER_RD: next_state = S_USER_WAIT;
      S_USER_WAIT:
      begin
        if (otp_ack_i)
          next_state = S_PACE;
      end
      S_PACE:
      begin
        if (pace_last)
          next_state = copy_more ? S_USER_RD : after_load; // R2
      end
      S_WAIT_RUN:
      begin
        if (run_por || run_sys)
          next_state = S_RUN; // R13 R23
      end
      S_RUN: next_state = S_RUN;
      default: next_state = S_RESET;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart)
      state <= S_RESET; // R4 R11
    else
      state <= next_state;
  end
  // fixed part of the boot time runs from the start of boot, in parallel with config reads
  always_ff @(posedge clk_i)
  begin
    if (state == S_RESET)
    begin
      fixed_cnt <= '0;
      boot_cyc <= '0;
    end
    else
    begin
      if (!fixed_done)
        fixed_cnt <= fixed_cnt + 1'b1; // R2 R3
      if (boot_cyc != BCW'(BOOT_LIMIT_CYC + 1))
        boot_cyc <= boot_cyc + 1'b1;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (state != S_PACE)
      pace_cnt <= '0;
    else
      pace_cnt <= pace_cnt + 1'b1; // R2
  end
  // ---------------------------------------------------------------
  // configuration capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      autorun <= 1'b0;
    else if (cfg_take && (cfg_idx == CFG_PROT) && otp_rdata_i[PROT_AUTORUN_BIT])
      autorun <= 1'b1; // R21
  end
  // every boot rebuilds its state from the OTP; only autorun, and skip on a debug reset, are kept from before
  always_ff @(posedge clk_i)
  begin
    if (state == S_RESET)
    begin
      cfg_idx <= 3'h0; // R8
      level <= 3'h0;
      ubeg <= 16'h0000;
      ulen <= 16'h0000;
      internal_data_ram_len <= 8'h00;
      copied <= 16'h0000;
    end
    else
    begin
      if (cfg_take)
      begin
        cfg_idx <= cfg_idx + 1'b1;
        case (cfg_idx)
          CFG_LEVEL: level <= otp_rdata_i[2:0]; // R9 R10
          CFG_UBEG_HI: ubeg[15:8] <= otp_rdata_i;
          CFG_UBEG_LO: ubeg[7:0] <= otp_rdata_i;
          CFG_ULEN_HI: ulen[15:8] <= otp_rdata_i;
          CFG_ULEN_LO: ulen[7:0] <= otp_rdata_i;
          CFG_INTERNAL_DATA_RAM_LEN: internal_data_ram_len <= otp_rdata_i;
          default: ;
        endcase
      end
      if (user_take)
        copied <= copied + 1'b1; // R14
    end
  end
  // ---------------------------------------------------------------
  // OTP reads and RAM writes
  // ---------------------------------------------------------------
  // the OTP is only read here, never through a CPU path
  always_ff @(posedge clk_i)
  begin
    if (rst_i || restart)
    begin
      otp_req_o <= '0;
      ram_wr_o <= '0;
    end
    else
    begin
      otp_req_o.rd <= (next_state == S_CFG_WAIT) || (next_state == S_USER_WAIT); // R17
      if (state == S_CFG_RD)
        otp_req_o.addr <= {{(OTP_AW-3){1'b0}}, cfg_idx}; // R9
      else if (state == S_USER_RD)
        otp_req_o.addr <= user_sum[OTP_AW-1:0]; // R19
      ram_wr_o.we <= cfg_take || user_take;
      ram_wr_o.internal_data_ram <= user_take && to_internal_data_ram; // R14
      ram_wr_o.addr <= cfg_take ? cfg_ram_addr : user_ram_addr; // R12
      ram_wr_o.data <= otp_rdata_i;
    end
  end
  // ---------------------------------------------------------------
  // CPU, ports and debug control
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cpu_run_o <= 1'b0;
      cpu_pc_o <= RUN_ADDR; // R7
      periph_rst_o <= 1'b1; // R5
      port_latch_o <= PORT_RESET_VAL; // R6
      port_od_o <= 1'b1;
      osc_int_sel_o <= 1'b1; // R7
      debug_en_o <= 1'b0;
      prog_allow_o <= 1'b0;
    end
    else
    begin
      // pc, port and clock-select flops simply keep their reset values
      cpu_run_o <= !restart && (next_state == S_RUN); // R1 R23
      periph_rst_o <= restart || (next_state == S_RESET); // R5
      debug_en_o <= !restart && boot_done && debug_allow; // R15 R20 R22
      prog_allow_o <= !restart && boot_done && !lvl_run(level); // R16
    end
  end
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_por <= 1'b0;
      run_sys <= 1'b0;
      skip <= 1'b0; // R20
    end
    else
    begin
      run_por <= next_run_por; // R13
      run_sys <= next_run_sys;
      skip <= next_skip;
    end
  end
  always_comb
  begin
    flags_word = 32'h0000_0000;
    flags_word[FLG_RUN_POR] = run_por;
    flags_word[FLG_RUN_SYS] = run_sys;
    flags_word[FLG_SKIP] = skip;
    flags_word[FLG_DONE] = boot_done;
    flags_word[FLG_WAIT] = state == S_WAIT_RUN;
    prot_word = 32'h0000_0000;
    prot_word[2:0] = level; // R10
    prot_word[PROT_AUTORUN_POS] = autorun;
    prot_word[PROT_DEBUG_POS] = debug_en_o;
    prot_word[PROT_PROG_POS] = prog_allow_o;
  end
  wire [31:0] rd_mux = (wb_adr_i == REG_PROT_LEVEL) ? prot_word :
                       (wb_adr_i == REG_BOOT_FLAGS) ? flags_word :
                       (wb_adr_i == REG_BOOT_STATUS) ? {copied, 12'h000, state} :
                       (wb_adr_i == REG_USER_INFO) ? {ubeg, ulen} : 32'h0000_0000;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      if (wb_req)
        wb_dat_o <= rd_mux;
    end
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_run_pc_zero: assert property (cpu_run_o |-> (cpu_pc_o == RUN_ADDR) && boot_done) // R1
    else $error("cpu released away from address zero or before boot end");
  a_run_after_load: assert property ($rose(cpu_run_o) |-> (copied == ulen_eff) || $past(state == S_WAIT_RUN)) // R1
    else $error("cpu released before the user copy completed");
  a_wait_release: assert property ((state == S_WAIT_RUN) && (run_por || run_sys) && !restart |=> cpu_run_o) // R23
    else $error("run request did not release the cpu");
  a_factory_waits: assert property ((state == S_WAIT_RUN) && !run_por && !run_sys && !restart |=> !cpu_run_o) // R13
    else $error("cpu released without a run request");
  a_halt_in_boot: assert property (!boot_done |-> !cpu_run_o) // R5
    else $error("cpu running during boot");
  a_run_locked: assert property (boot_done && lvl_run(level) && !restart |=>
                                 !prog_allow_o && (debug_en_o == $past(retest_s))) // R16
    else $error("run part left programming or debug open");
  a_ports_reset: assert property ($past(rst_i) |-> (port_latch_o == PORT_RESET_VAL) && port_od_o && periph_rst_o) // R6
    else $error("ports not at reset state after reset");
  a_skip_user: assert property ((state == S_FIXED) && (next_state == S_USER_RD) |-> !skip_load && lvl_loads(level)) // R20
    else $error("user load started although skipped or not loadable");
  a_user_clip: assert property (otp_req_o.rd && (state == S_USER_WAIT) |->
                                {{(16-OTP_AW){1'b0}}, otp_req_o.addr} < OTP_USER_LIMIT) // R18
    else $error("user copy reached the reserved tail");
  a_autorun_sticky: assert property ($past(autorun) |-> autorun) // R21
    else $error("autorun bit returned to zero");
  a_factory_fast: assert property ($rose(boot_done) && !lvl_loads(level) |-> boot_cyc < BCW'(BOOT_LIMIT_CYC)) // R3
    else $error("factory-only boot took 2 ms or more");
  a_byte_pace: assert property ($rose(state == S_USER_RD) |->
                                $past(state == S_FIXED) || ($past(pace_cnt) == PACE_W'(BYTE_PACE_CYC - 1))) // R2
    else $error("user byte read before its pacing slot ended");
  c_factory_wait: cover property ($rose(state == S_WAIT_RUN) && (level == LVL_FACTORY));
  c_user_byte: cover property (user_take && to_internal_data_ram);
  c_run_jump: cover property ($rose(cpu_run_o) && lvl_run(level));
  c_autorun: cover property ($rose(cpu_run_o) && (level == LVL_USER) && autorun);
endmodule

// >>> hw/boot_pkg.sv
// Constants, types and register map shared by the OTP boot sequencer.
// Function
// [R1] Copy OTP loads, then run at 0x0000.
// [R2] Boot takes 2 ms plus 3.6 ms/kB.
// [R3] Factory-only boot ends under 2 ms.
// [R4] Power-on reset is the only external reset.
// [R5] Reset halts CPU, resets registers, ports, timers.
// [R6] Port latches reset to 0xFF, open-drain.
// [R7] Leaving reset: clear PC, internal oscillator, boot.
// [R8] No data memory survives a reset.
// [R9] Read factory config first, pick path by level.
// [R10] Program level readable as 3-bit field.
// [R11] Power cycle, wake or debug reset starts boot.
// [R12] Write config into registers and boot block.
// [R13] Factory level waits for a run request flag.
// [R14] User level copies user region, then waits.
// [R15] Run level jumps to 0x0000, debug off; the code turns debug on while retest_i is high.
// [R16] Run level refuses programming and debug; the code still opens debug while retest_i is high.
// [R17] OTP mapped virtually at 0xE000..0xFFFF, no direct reads.
// [R18] Last 64 OTP bytes never user load.
// [R19] Boot copies only the user region.
// [R20] Skip flag: no user load, debug on, wait.
// [R21] Autorun bit never returns to zero.
// [R22] User level with autorun: debug on, run immediately.
// [R23] Run request releases CPU at address zero.
package boot_pkg;
  localparam int CLK_MHZ = 125;
  localparam int BOOT_FIXED_US = 2000;
  localparam int USER_PER_KB_US = 3600;
  localparam int KB_BYTES = 1024;
  // ---------------------------------------------------------------
  // cycle counts
  // ---------------------------------------------------------------
  localparam int BOOT_LIMIT_CYC = BOOT_FIXED_US * CLK_MHZ;
  // boot_done lands one cycle after the count ends; stop two short to stay under 2 ms
  localparam int FIXED_CYC_DEF = BOOT_LIMIT_CYC - 2;
  localparam int BYTE_PACE_CYC = (USER_PER_KB_US * CLK_MHZ) / KB_BYTES;
  localparam int PACE_W = $clog2(BYTE_PACE_CYC);
  // ---------------------------------------------------------------
  // OTP and RAM layout
  // ---------------------------------------------------------------
  localparam int OTP_AW = 13;
  localparam int OTP_SIZE = 8192;
  localparam int OTP_RSVD_BYTES = 64;
  localparam logic [15:0] OTP_USER_LIMIT = 16'(OTP_SIZE - OTP_RSVD_BYTES);
  localparam logic [15:0] OTP_VIRT_BASE = 16'hE000;
  localparam logic [15:0] OTP_VIRT_END = 16'hFFFF;
  localparam int RAM_AW = 13;
  localparam logic [RAM_AW-1:0] BOOT_BLK_BASE = 13'h11F3;
  localparam logic [15:0] RUN_ADDR = 16'h0000;
  localparam logic [7:0] PORT_RESET_VAL = 8'hFF;
  // factory config byte positions at the start of the OTP
  localparam int CFG_BYTES = 7;
  localparam logic [2:0] CFG_LEVEL = 3'h0;
  localparam logic [2:0] CFG_PROT = 3'h1;
  localparam logic [2:0] CFG_UBEG_HI = 3'h2;
  localparam logic [2:0] CFG_UBEG_LO = 3'h3;
  localparam logic [2:0] CFG_ULEN_HI = 3'h4;
  localparam logic [2:0] CFG_ULEN_LO = 3'h5;
  localparam logic [2:0] CFG_INTERNAL_DATA_RAM_LEN = 3'h6;
  localparam int PROT_AUTORUN_BIT = 0;
  localparam logic [2:0] LVL_FACTORY = 3'h1;
  localparam logic [2:0] LVL_USER = 3'h3;
  localparam logic [2:0] LVL_RUN = 3'h7;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int WB_AW = 8;
  localparam logic [WB_AW-1:0] REG_PROT_LEVEL = 8'h00;
  localparam logic [WB_AW-1:0] REG_BOOT_FLAGS = 8'h04;
  localparam logic [WB_AW-1:0] REG_BOOT_STATUS = 8'h08;
  localparam logic [WB_AW-1:0] REG_USER_INFO = 8'h0C;
  localparam int FLG_RUN_POR = 0;
  localparam int FLG_RUN_SYS = 1;
  localparam int FLG_SKIP = 2;
  localparam int FLG_DONE = 8;
  localparam int FLG_WAIT = 9;
  localparam int PROT_AUTORUN_POS = 3;
  localparam int PROT_DEBUG_POS = 4;
  localparam int PROT_PROG_POS = 5;

  typedef enum logic [3:0] {
    S_RESET = 4'h0,
    S_CFG_RD = 4'h1,
    S_CFG_WAIT = 4'h2,
    S_FIXED = 4'h3,
    S_USER_RD = 4'h4,
    S_USER_WAIT = 4'h5,
    S_PACE = 4'h6,
    S_WAIT_RUN = 4'h7,
    S_RUN = 4'h8
  } state_e;

  typedef struct packed {
    logic rd;
    logic [OTP_AW-1:0] addr;
  } otp_req_s;

  typedef struct packed {
    logic we;
    logic internal_data_ram;
    logic [RAM_AW-1:0] addr;
    logic [7:0] data;
  } ram_wr_s;
endpackage

// >>> sim/otp_model.sv
// OTP array model: answers byte reads after a short or a long delay.
`timescale 1ns/1ps
module otp_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input boot_pkg::otp_req_s req_i,
  output logic [7:0] rdata_o,
  output logic ack_o,
  output logic rsvd_hit_o
);
  import boot_pkg::*;
  logic [7:0] mem [0:OTP_SIZE-1];
  int cnt;

  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    rdata_o = 8'h00;
    ack_o = 1'b0;
    rsvd_hit_o = 1'b0;
    cnt = 0;
  end

  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    // data line undriven outside the answer cycle: keep it moving
    if (!ack_o)
      rdata_o <= ~rdata_o;
    if (req_i.rd && !ack_o)
    begin
      if ({3'h0, req_i.addr} >= OTP_USER_LIMIT)
        rsvd_hit_o <= 1'b1;
      cnt <= cnt + 1;
      if (cnt >= (slow_i ? 6 : 0))
      begin
        ack_o <= 1'b1;
        rdata_o <= mem[req_i.addr];
        cnt <= 0;
      end
    end
  end
endmodule

// >>> sim/otp_boot_loader_sequencer_test.sv
// Self-checking bench for the OTP boot sequencer.
`timescale 1ns/1ps
module otp_boot_loader_sequencer_test;
  import boot_pkg::*;
  localparam int FIX = 40;
  logic clk_i, rst_i, wake_i, dbg_reset_i, retest_i, slow, otp_ack, rsvd_hit, wb_we, wb_cyc, wb_stb, wb_ack;
  logic cpu_run, periph_rst, port_od, osc_int_sel, debug_en, prog_allow;
  logic [7:0] otp_rdata, port_latch, wb_adr;
  logic [15:0] cpu_pc;
  logic [31:0] wb_dat, wb_rdat, q;
  logic [3:0] wb_sel;
  otp_req_s otp_req;
  ram_wr_s ram_wr;
  int n_mismatch, n_tests, cyc_cnt, n_user, n_internal_data_ram, n_blk, n_bad, internal_data_ram_n, t;

  otp_boot_loader_sequencer #(.FIXED_CYCLES(FIX)) otp_boot_loader_sequencer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wake_i(wake_i), .dbg_reset_i(dbg_reset_i), .retest_i(retest_i),
    .otp_rdata_i(otp_rdata), .otp_ack_i(otp_ack), .otp_req_o(otp_req), .ram_wr_o(ram_wr),
    .cpu_run_o(cpu_run), .cpu_pc_o(cpu_pc), .periph_rst_o(periph_rst), .port_latch_o(port_latch),
    .port_od_o(port_od), .osc_int_sel_o(osc_int_sel), .debug_en_o(debug_en), .prog_allow_o(prog_allow),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));

  otp_model otp_model_inst (.clk_i(clk_i), .slow_i(slow), .req_i(otp_req), .rdata_o(otp_rdata),
    .ack_o(otp_ack), .rsvd_hit_o(rsvd_hit));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // ------------------------------------------------------------
  // ram write monitor
  // ------------------------------------------------------------
  always @(posedge clk_i)
  begin
    cyc_cnt <= rst_i ? 0 : cyc_cnt + 1;
    if (!rst_i && ram_wr.we === 1'b1)
    begin
      if (ram_wr.internal_data_ram)
      begin
        n_internal_data_ram++;
        if (ram_wr.data !== 8'(8'hA0 + ram_wr.addr[7:0])) n_bad++;
      end
      else if (ram_wr.addr >= BOOT_BLK_BASE) n_blk++;
      else
      begin
        n_user++;
        if (ram_wr.data !== 8'(8'hA0 + internal_data_ram_n + ram_wr.addr[7:0])) n_bad++;
      end
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task chk(input bit ok, input string msg);
    n_tests++;
    if (!ok)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (wb_ack !== 1'b1 && k < 50);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (k >= 50) chk(1'b0, "bus never answered");
  endtask

  task boot(input logic [7:0] lvl, prot, input logic [15:0] ub, ul, input logic [7:0] ir);
    rst_i <= 1'b1;
    otp_model_inst.mem[0] = lvl;
    otp_model_inst.mem[1] = prot;
    otp_model_inst.mem[2] = ub[15:8];
    otp_model_inst.mem[3] = ub[7:0];
    otp_model_inst.mem[4] = ul[15:8];
    otp_model_inst.mem[5] = ul[7:0];
    otp_model_inst.mem[6] = ir;
    for (int i = 0; i < ul; i++) otp_model_inst.mem[ub + i] = 8'(8'hA0 + i);
    repeat (3) @(posedge clk_i);
    chk(periph_rst === 1'b1 && cpu_run === 1'b0 && port_latch === PORT_RESET_VAL && port_od === 1'b1
      && osc_int_sel === 1'b1 && debug_en === 1'b0 && cpu_pc === RUN_ADDR, "reset outputs");
    internal_data_ram_n = ir;
    n_user = 0;
    n_internal_data_ram = 0;
    n_blk = 0;
    n_bad = 0;
    rst_i <= 1'b0;
  endtask

  task wait_done();
    int k;
    k = 0;
    do
    begin
      wb(1'b0, REG_BOOT_FLAGS, 32'h0);
      k++;
    end
    while (q[FLG_DONE] !== 1'b1 && k < 2000);
    t = cyc_cnt;
    chk(k < 2000, "boot never finished");
  endtask

  task wait_run(input bit exp, input string m);
    int k;
    k = 0;
    while (cpu_run !== 1'b1 && k < 8)
    begin
      @(posedge clk_i);
      k++;
    end
    chk((cpu_run === 1'b1) == exp && cpu_pc === RUN_ADDR, m);
  endtask

  // wake clears the skip flag, a debug reset keeps it
  task restart(input bit use_wake);
    if (use_wake) wake_i <= 1'b1;
    else dbg_reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake_i <= 1'b0;
    dbg_reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_factory();
    boot(LVL_FACTORY, 8'h00, 16'h0100, 16'h0000, 8'h00);
    wait_done();
    chk(t >= FIX && t <= FIX + 40, "factory boot time");
    chk(n_blk === 7 && n_user === 0 && n_internal_data_ram === 0, "factory writes");
    chk(q[FLG_WAIT] === 1'b1, "not waiting");
    wait_run(1'b0, "factory part ran");
    wb(1'b0, REG_PROT_LEVEL, 32'h0);
    chk(q[2:0] === LVL_FACTORY && q[PROT_DEBUG_POS] === 1'b1 && q[PROT_PROG_POS] === 1'b1, "level reg");
    chk(debug_en === 1'b1 && prog_allow === 1'b1 && periph_rst === 1'b0, "factory debug/prog");
    wb(1'b0, 8'h10, 32'h0);
    chk(q === 32'h0, "unmapped read");
    wb(1'b1, REG_BOOT_FLAGS, 32'h2);
    wait_run(1'b1, "run after sys flag");
    $display("test factory done");
  endtask

  task t_user();
    boot(LVL_USER, 8'h00, 16'h0100, 16'h0004, 8'h01);
    wait_done();
    chk(t >= 3 * BYTE_PACE_CYC && t <= FIX + 4 * BYTE_PACE_CYC + 60, "user boot time");
    chk(n_internal_data_ram === 1 && n_user === 3 && n_bad === 0, "user copy");
    wb(1'b0, REG_USER_INFO, 32'h0);
    chk(q === 32'h0100_0004, "user info reg");
    wb(1'b0, REG_BOOT_STATUS, 32'h0);
    chk(q === {16'h0004, 12'h000, S_WAIT_RUN}, "boot status reg");
    wait_run(1'b0, "user part ran");
    chk(debug_en === 1'b1, "user debug");
    wb(1'b1, REG_BOOT_FLAGS, 32'h1);
    wait_run(1'b1, "run after por flag");
    $display("test user done");
  endtask

  task t_autorun();
    boot(LVL_USER, 8'h01, 16'h0200, 16'h0002, 8'h00);
    wait_done();
    wait_run(1'b1, "autorun did not run");
    chk(debug_en === 1'b1 && n_user === 2, "autorun debug");
    otp_model_inst.mem[1] = 8'h00;
    restart(1'b0);
    chk(cpu_run === 1'b0, "restart kept cpu");
    wait_done();
    wait_run(1'b1, "autorun lost");
    $display("test autorun done");
  endtask

  task t_run();
    slow <= 1'b1;
    boot(LVL_RUN, 8'h00, 16'h0300, 16'h0002, 8'h00);
    wait_done();
    wait_run(1'b1, "run part idle");
    chk(debug_en === 1'b0 && prog_allow === 1'b0 && n_user === 2 && n_bad === 0, "run locks");
    wb(1'b1, REG_PROT_LEVEL, 32'h0);
    wb(1'b0, REG_PROT_LEVEL, 32'h0);
    chk(q[2:0] === LVL_RUN && q[PROT_DEBUG_POS] === 1'b0, "level reg run");
    retest_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(debug_en === 1'b1, "retest debug");
    retest_i <= 1'b0;
    slow <= 1'b0;
    $display("test run done");
  endtask

  task t_skip();
    boot(LVL_USER, 8'h00, 16'h0100, 16'h0003, 8'h00);
    wait_done();
    wb(1'b1, REG_BOOT_FLAGS, 32'h4);
    n_user = 0;
    restart(1'b0);
    wait_done();
    chk(n_user === 0 && debug_en === 1'b1, "skip load");
    wait_run(1'b0, "skip part ran");
    restart(1'b1);
    wait_done();
    chk(n_user === 3 && n_bad === 0, "wake load");
    $display("test skip done");
  endtask

  task t_rsvd();
    boot(LVL_USER, 8'h00, 16'h1FBE, 16'h0004, 8'h00);
    wait_done();
    chk(n_user === 2 && rsvd_hit === 1'b0, "reserved bytes read");
    $display("test reserved done");
  endtask

  task close_out();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    {rst_i, wake_i, dbg_reset_i, retest_i, slow, wb_we, wb_cyc, wb_stb} = 8'hFF;
    {wake_i, dbg_reset_i, retest_i, slow, wb_we, wb_cyc, wb_stb} = 7'h00;
    {wb_adr, wb_dat, wb_sel} = {8'h00, 32'h0, 4'hF};
    {n_mismatch, n_tests, cyc_cnt} = 96'h0;
    t_factory();
    t_user();
    t_autorun();
    t_run();
    t_skip();
    t_rsvd();
    close_out();
  end

  // hang guard: about seven times the expected run
  initial
  begin
    #480000;
    n_mismatch++;
    close_out();
  end
endmodule
